// ---- sim/capu_pin_load.sv ----
// Load on the output pin: pulled-down wire, counts its high cycles
`default_nettype none
module capu_pin_load (
    input  wire logic clk_i,
    input  wire logic clr_i,
    input  wire logic pin_i,
    input  wire logic oe_i,
    output var  logic [31:0] high_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pin reads low through the pull-down
    always @(posedge clk_i) high_o <= clr_i ? 32'h0 : high_o + 32'(pin_i & oe_i);
endmodule // capu_pin_load
`default_nettype wire

// ---- sim/capu_sva.sv ----
// Port assertions of the compare/PWM unit
`default_nettype none
module capu_sva (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic EVT_TICK_I,
    input wire logic SLEEP_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WREADY_O,
    input wire logic PIN_O,
    input wire logic PIN_OE_O,
    input wire logic TRIG_O,
    input wire logic ADC_START_O
);
    default clocking dc @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    // Trigger met by a counter tick, or idle with no write under way
    sequence s_hit; TRIG_O && EVT_TICK_I && !SLEEP_I; endsequence
    sequence s_wait; TRIG_O && !EVT_TICK_I && !SLEEP_I && S_AXI_AWREADY_O && S_AXI_WREADY_O;
    endsequence
    property p_rst; s_hit |=> !TRIG_O; endproperty
    a_rst: assert property (p_rst) else $error("trigger kept");
    property p_hold; s_wait |=> TRIG_O || SLEEP_I; endproperty
    a_hold: assert property (p_hold) else $error("trigger lost");
    property p_adc; ADC_START_O |-> $past(TRIG_O) && !$past(TRIG_O, 2); endproperty
    a_adc: assert property (p_adc) else $error("stray start");
    property p_pulse; ADC_START_O |=> !ADC_START_O; endproperty
    a_pulse: assert property (p_pulse) else $error("long start");
    property p_nopin; TRIG_O |-> !PIN_OE_O; endproperty
    a_nopin: assert property (p_nopin) else $error("pin driven");
    property p_slp; SLEEP_I |-> !TRIG_O; endproperty
    a_slp: assert property (p_slp) else $error("sleep trigger");
    property p_frz; SLEEP_I && $past(SLEEP_I) && S_AXI_WREADY_O && $past(S_AXI_WREADY_O)
        |-> $stable({PIN_O, PIN_OE_O}); endproperty
    a_frz: assert property (p_frz) else $error("pin moved");
    property p_sadc; SLEEP_I [*2] |-> !ADC_START_O; endproperty
    a_sadc: assert property (p_sadc) else $error("sleep start");
endmodule // capu_sva
bind capu_top capu_sva u_sva (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Register-level bench of the compare/PWM unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK_I = 1'b0, NRST_I = 1'b0, EVT_TICK_I = 1'b0, SLEEP_I = 1'b0, clr = 1'b1;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
    logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
    logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I = 4'hf, m;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, PIN_O, PIN_OE_O, TRIG_O, ADC_START_O;
    logic [23:0] p;
    logic [31:0] hi;
    int num_errors = 0, total_checks = 0, i;
    capu_top uut (.*);
    capu_pin_load load (.clk_i(MCLK_I), .clr_i(clr), .pin_i(PIN_O), .oe_i(PIN_OE_O), .high_o(hi));
    always #5 MCLK_I = ~MCLK_I;
    task automatic ck(input logic [33:0] g, input logic [33:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, d};
        {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
        do @(posedge MCLK_I) {S_AXI_AWVALID_I, S_AXI_WVALID_I} <=
            {S_AXI_AWVALID_I & ~S_AXI_AWREADY_O, S_AXI_WVALID_I & ~S_AXI_WREADY_O};
        while (!S_AXI_BVALID_O);
        S_AXI_BREADY_I <= 1'b0;
        ck(S_AXI_BRESP_O, r);
        @(posedge MCLK_I);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        {S_AXI_ARADDR_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} <= {a, 2'h3};
        do @(posedge MCLK_I) S_AXI_ARVALID_I <= S_AXI_ARVALID_I & ~S_AXI_ARREADY_O;
        while (!S_AXI_RVALID_O);
        S_AXI_RREADY_I <= 1'b0;
        ck({S_AXI_RRESP_O, S_AXI_RDATA_O}, {r, e});
        @(posedge MCLK_I);
    endtask
    task automatic tk(input int n);
        repeat (2 * n) @(posedge MCLK_I) EVT_TICK_I <= ~EVT_TICK_I;
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge MCLK_I);
        NRST_I <= 1'b1;
        @(posedge MCLK_I);
        rd(8'h0c, 32'hff);
        rd(8'h30, 32'h0, 2'h2);
        wr(8'h20, 32'h2);
        wr(8'h04, 32'h2);
        for (i = 0; i < 5; i++) begin
            m = 4'(20'h8980a >> (4 * (4 - i)));
            wr(8'h14, 32'h0);
            wr(8'h00, {28'h0, m});
            tk(2);
            repeat (2) @(posedge MCLK_I);
            ck({PIN_O, PIN_OE_O}, {m == 4'h8, m[3] & ~m[1]});
            rd(8'h1c, {31'h0, m[3]});
            wr(8'h1c, 32'h7);
        end
        wr(8'h14, 32'h0);
        wr(8'h04, 32'h5);
        wr(8'h00, 32'hb);
        tk(5);
        repeat (2) @(posedge MCLK_I);
        ck({TRIG_O, PIN_OE_O, ADC_START_O}, 34'h5);
        tk(1);
        rd(8'h14, 32'h0);
        rd(8'h1c, 32'h1);
        tk(5);
        wr(8'h04, 32'h7);
        tk(1);
        rd(8'h14, 32'h6);
        wr(8'h1c, 32'h7);
        wr(8'h08, 32'hff);
        wr(8'h04, 32'hff);
        wr(8'h14, 32'hffff);
        tk(1);
        rd(8'h1c, 32'h1);
        wr(8'h0c, 32'h3);
        wr(8'h10, 32'h7c);
        for (i = 0; i < 4; i++) begin
            p = 24'(96'h0c0000_0cff20_2c010c_3e0112 >> (24 * (3 - i)));
            wr(8'h04, {24'h0, p[15:8]});
            wr(8'h00, {24'h0, p[23:16]});
            repeat (40) @(posedge MCLK_I);
            clr <= 1'b0;
            repeat (33) @(posedge MCLK_I);
            ck(hi, {26'h0, p[7:0]});
            clr <= 1'b1;
            wr(8'h08, 32'h55);
            rd(8'h08, {24'h0, p[15:8]});
        end
        SLEEP_I <= 1'b1;
        wr(8'h18, 32'h2);
        repeat (20) @(posedge MCLK_I);
        rd(8'h18, 32'h2);
        SLEEP_I <= 1'b0;
        wr(8'h00, 32'h0);
        ck(PIN_OE_O, 34'h0);
        give_verdict();
    end
    // Watchdog
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire

// ---- src/capu_map.svh ----
// Register offsets, field positions, reset values and timing counts of the compare/PWM unit
`ifndef CAPU_MAP_SVH
`define CAPU_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CAPU_OFS_CTRL     8'h00
`define CAPU_OFS_DUTY_LO  8'h04
`define CAPU_OFS_DUTY_HI  8'h08
`define CAPU_OFS_PLIM     8'h0c
`define CAPU_OFS_PTCTL    8'h10
`define CAPU_OFS_EVCNT    8'h14
`define CAPU_OFS_PCNT     8'h18
`define CAPU_OFS_STAT     8'h1c
`define CAPU_OFS_AUX      8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CAPU_CTL_DC_LSB   4
`define CAPU_PT_ON_BIT    2
`define CAPU_ST_MATCH     0
`define CAPU_ST_OVF       1
`define CAPU_ST_PEND      2
`define CAPU_AUX_DIR      0
`define CAPU_AUX_ADC      1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CAPU_RST_CTRL     6'h00
`define CAPU_RST_PLIM     8'hff
`define CAPU_RST_PTCTL    7'h00
`define CAPU_RST_AUX      2'h1

// ----------------------------------------------------------------------------
// Timing: last sub-count of one period-counter step, in oscillator periods
// ----------------------------------------------------------------------------
`define CAPU_SUB_MAX_1    6'h03
`define CAPU_SUB_MAX_4    6'h0f
`define CAPU_SUB_MAX_16   6'h3f

`endif

// ---- src/capu_pkg.sv ----
// Types shared by the compare/PWM unit modules
`default_nettype none
package capu_pkg;
    // Mode select codes
    typedef enum logic [3:0] {
        CAPU_MODE_OFF  = 4'h0,
        CAPU_MODE_SET  = 4'h8,
        CAPU_MODE_CLR  = 4'h9,
        CAPU_MODE_SWI  = 4'ha,
        CAPU_MODE_TRIG = 4'hb
    } capu_mode_t;

    // Register selected by an address
    typedef enum logic [3:0] {
        CAPU_R_NONE = 4'h0, CAPU_R_CTRL = 4'h1, CAPU_R_DLO = 4'h2,
        CAPU_R_DHI = 4'h3, CAPU_R_PLIM = 4'h4, CAPU_R_PTCTL = 4'h5,
        CAPU_R_EVCNT = 4'h6, CAPU_R_PCNT = 4'h7, CAPU_R_STAT = 4'h8,
        CAPU_R_AUX = 4'h9
    } capu_reg_t;
endpackage
`default_nettype wire

// ---- src/capu_pwm.sv ----
// Period counter, 10-bit time base and PWM level generator
`include "capu_map.svh"
`default_nettype none
module capu_pwm (
    input wire logic clk_i,
    input wire logic rst_n_i,
    capu_pwm_if.pwm  pif
);
    logic [5:0] sub_q;
    logic [7:0] cnt_q;
    logic [1:0] lat_q;
    logic       lvl_q;
    logic [5:0] sub_max;
    logic [1:0] lo2;
    logic       fine;
    logic       step;
    logic       pend;
    logic [9:0] tb_next;
    logic [9:0] new_duty;

    // ------------------------------------------------------------------------
    // Time base decode
    // ------------------------------------------------------------------------
    // Low two time-base bits: clock phase at 1:1, else prescaler bits
    always_comb begin
        case (pif.prescale)
            2'b00: begin
                sub_max = `CAPU_SUB_MAX_1;
                lo2     = sub_q[1:0];
                fine    = 1'b1;
            end
            2'b01: begin
                sub_max = `CAPU_SUB_MAX_4;
                lo2     = sub_q[3:2];
                fine    = (sub_q[1:0] == 2'h3);
            end
            default: begin
                sub_max = `CAPU_SUB_MAX_16;
                lo2     = sub_q[5:4];
                fine    = (sub_q[3:0] == 4'hf);
            end
        endcase
    end

    // Postscaler plays no part: period set by prescale and limit only
    assign step     = pif.run & (sub_q >= sub_max);
    assign pend     = step & (cnt_q == pif.period_limit);
    assign tb_next  = {cnt_q, lo2} + 10'h001;
    assign new_duty = {pif.duty_low, pif.duty_lsb};

    assign pif.cnt        = cnt_q;
    assign pif.period_end = pend;
    assign pif.level      = lvl_q;

    // ------------------------------------------------------------------------
    // Counters; only a software count write moves them while run is low (sleep or timer off)
    // ------------------------------------------------------------------------
    // Sub-count of oscillator periods inside one counter step
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sub_q <= 6'h00;
        end else if (pif.run) begin
            sub_q <= step ? 6'h00 : sub_q + 6'h01;
        end
    end

    // Period counter, cleared at the period end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else if (pif.cnt_wr) begin
            cnt_q <= pif.cnt_wdata;
        end else if (step) begin
            cnt_q <= pend ? 8'h00 : cnt_q + 8'h01;
        end
    end

    // Two-bit duty latch, loaded with the two duty LSBs at the period end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lat_q <= 2'h0;
        end else if (pend) begin
            lat_q <= pif.duty_lsb;
        end
    end

    // Level: set at period end unless 0%, cleared where time base hits duty
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lvl_q <= 1'b0;
        end else if (!pif.pwm_en) begin
            lvl_q <= 1'b0;
        end else if (pend) begin
            lvl_q <= (new_duty != 10'h000);
        end else if (pif.run && fine && tb_next == {pif.duty_high, lat_q}) begin
            lvl_q <= 1'b0;
        end
    end
endmodule // capu_pwm
`default_nettype wire

// ---- src/capu_pwm_if.sv ----
// Signals between the register side and the PWM time base
`default_nettype none
interface capu_pwm_if;
    logic       pwm_en;
    logic       run;
    logic [1:0] prescale;
    logic [7:0] period_limit;
    logic [7:0] duty_low;
    logic [1:0] duty_lsb;
    logic [7:0] duty_high;
    logic       cnt_wr;
    logic [7:0] cnt_wdata;
    logic [7:0] cnt;
    logic       period_end;
    logic       level;

    modport ctl (output pwm_en, run, prescale, period_limit, duty_low, duty_lsb,
                 duty_high, cnt_wr, cnt_wdata, input cnt, period_end, level);
    modport pwm (input pwm_en, run, prescale, period_limit, duty_low, duty_lsb,
                 duty_high, cnt_wr, cnt_wdata, output cnt, period_end, level);
endinterface
`default_nettype wire

// ---- src/capu_top.sv ----
// Compare and PWM unit: AXI4-Lite registers, compare logic and pin control
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "capu_map.svh"
`default_nettype none
module capu_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              MCLK_I,
    input  wire logic              NRST_I,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    input  wire logic              EVT_TICK_I,
    input  wire logic              SLEEP_I,
    output logic                   PIN_O,
    output logic                   PIN_OE_O,
    output logic                   TRIG_O,
    output logic                   ADC_START_O
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    capu_pwm_if pif ();

    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_have_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              w_have_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic              do_wr;
    capu_pkg::capu_reg_t wsel;
    capu_pkg::capu_reg_t rsel;
    logic [31:0]       rmux;

    logic [5:0]        ctrl_q;      // module_control_reg
    logic [7:0]        dlo_q;       // compare_duty_low_reg
    logic [7:0]        dhi_q;       // compare_duty_high_reg
    logic [7:0]        plim_q;      // period_limit_reg
    logic [6:0]        ptctl_q;     // period_timer_control
    logic [15:0]       evcnt_q;     // event_counter
    logic [2:0]        stat_q;
    logic [1:0]        aux_q;
    logic              cmp_lat_q;
    logic              match_q;
    logic              trig_q;
    logic              adc_q;

    capu_pkg::capu_mode_t mode;
    logic              is_cmp;
    logic              is_pwm;
    logic              match;
    logic              match_rise;
    logic              trig;
    logic              awake;
    logic              tick;
    logic              wr_ctrl;
    logic              drive;

    // Address decode shared by reads and writes
    function automatic capu_pkg::capu_reg_t dec(input logic [ADDR_W-1:0] a);
        capu_pkg::capu_reg_t r;
        r = capu_pkg::CAPU_R_NONE;
        if (a == `CAPU_OFS_CTRL) begin
            r = capu_pkg::CAPU_R_CTRL;
        end else if (a == `CAPU_OFS_DUTY_LO) begin
            r = capu_pkg::CAPU_R_DLO;
        end else if (a == `CAPU_OFS_DUTY_HI) begin
            r = capu_pkg::CAPU_R_DHI;
        end else if (a == `CAPU_OFS_PLIM) begin
            r = capu_pkg::CAPU_R_PLIM;
        end else if (a == `CAPU_OFS_PTCTL) begin
            r = capu_pkg::CAPU_R_PTCTL;
        end else if (a == `CAPU_OFS_EVCNT) begin
            r = capu_pkg::CAPU_R_EVCNT;
        end else if (a == `CAPU_OFS_PCNT) begin
            r = capu_pkg::CAPU_R_PCNT;
        end else if (a == `CAPU_OFS_STAT) begin
            r = capu_pkg::CAPU_R_STAT;
        end else if (a == `CAPU_OFS_AUX) begin
            r = capu_pkg::CAPU_R_AUX;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel: address and data taken in either order
    // ------------------------------------------------------------------------
    assign S_AXI_AWREADY_O = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY_O  = !w_have_q && !bvalid_q;
    assign S_AXI_BVALID_O  = bvalid_q;
    assign S_AXI_BRESP_O   = bresp_q;
    assign do_wr           = aw_have_q && w_have_q && !bvalid_q;
    assign wsel            = dec(awaddr_q);

    // Write address holding
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR_I;
        end else if (do_wr) begin
            aw_have_q <= 1'b0;
        end
    end

    // Write data holding
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            w_have_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_have_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA_I;
            wstrb_q  <= S_AXI_WSTRB_I;
        end else if (do_wr) begin
            w_have_q <= 1'b0;
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'b00;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == capu_pkg::CAPU_R_NONE) ? 2'b10 : 2'b00;
        end else if (S_AXI_BREADY_I) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel: answer one cycle after the address is taken
    // ------------------------------------------------------------------------
    assign S_AXI_ARREADY_O = !rvalid_q;
    assign S_AXI_RVALID_O  = rvalid_q;
    assign S_AXI_RRESP_O   = rresp_q;
    assign S_AXI_RDATA_O   = rdata_q;
    assign rsel            = dec(S_AXI_ARADDR_I);

    // Read multiplexer; unused bits read as zero
    always_comb begin
        rmux = 32'h0000_0000;
        case (rsel)
            capu_pkg::CAPU_R_CTRL:  rmux[5:0]  = ctrl_q;
            capu_pkg::CAPU_R_DLO:   rmux[7:0]  = dlo_q;
            capu_pkg::CAPU_R_DHI:   rmux[7:0]  = dhi_q;
            capu_pkg::CAPU_R_PLIM:  rmux[7:0]  = plim_q;
            capu_pkg::CAPU_R_PTCTL: rmux[6:0]  = ptctl_q;
            capu_pkg::CAPU_R_EVCNT: rmux[15:0] = evcnt_q;
            capu_pkg::CAPU_R_PCNT:  rmux[7:0]  = pif.cnt;
            capu_pkg::CAPU_R_STAT:  rmux[2:0]  = stat_q;
            capu_pkg::CAPU_R_AUX:   rmux[1:0]  = aux_q;
            default:                rmux       = 32'h0000_0000;
        endcase
    end

    // Read data and response
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            rvalid_q <= 1'b0;
            rresp_q  <= 2'b00;
            rdata_q  <= 32'h0000_0000;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rmux;
            rresp_q  <= (rsel == capu_pkg::CAPU_R_NONE) ? 2'b10 : 2'b00;
        end else if (S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    assign wr_ctrl = do_wr && wsel == capu_pkg::CAPU_R_CTRL && wstrb_q[0];

    // Control, duty low, period limit, timer control, pin direction
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ctrl_q  <= `CAPU_RST_CTRL;
            dlo_q   <= 8'h00;
            plim_q  <= `CAPU_RST_PLIM;
            ptctl_q <= `CAPU_RST_PTCTL;
            aux_q   <= `CAPU_RST_AUX;
        end else if (do_wr && wstrb_q[0]) begin
            case (wsel)
                capu_pkg::CAPU_R_CTRL:  ctrl_q  <= wdata_q[5:0];
                capu_pkg::CAPU_R_DLO:   dlo_q   <= wdata_q[7:0];
                capu_pkg::CAPU_R_PLIM:  plim_q  <= wdata_q[7:0];
                capu_pkg::CAPU_R_PTCTL: ptctl_q <= wdata_q[6:0];
                capu_pkg::CAPU_R_AUX:   aux_q   <= wdata_q[1:0];
                default:                ;
            endcase
        end
    end

    // High byte: software owns it outside PWM, period end loads it in PWM
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            dhi_q <= 8'h00;
        end else if (is_pwm) begin
            if (pif.period_end) begin
                dhi_q <= dlo_q;
            end
        end else if (do_wr && wsel == capu_pkg::CAPU_R_DHI && wstrb_q[0]) begin
            dhi_q <= wdata_q[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Compare engine
    // ------------------------------------------------------------------------
    assign mode   = capu_pkg::capu_mode_t'(ctrl_q[3:0]);
    assign is_cmp = (ctrl_q[3:2] == 2'b10);
    assign is_pwm = (ctrl_q[3:2] == 2'b11);
    assign awake  = !SLEEP_I;
    assign tick   = EVT_TICK_I && awake;
    // Full 16-bit compare, evaluated every cycle
    assign match      = ({dhi_q, dlo_q} == evcnt_q);
    assign match_rise = is_cmp && awake && match && !match_q;
    // Trigger follows the match at once, not a clock later
    assign trig       = awake && mode == capu_pkg::CAPU_MODE_TRIG && match;
    assign TRIG_O     = trig;

    // Previous match, so each new match flags once
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            match_q <= 1'b0;
        end else if (awake) begin
            match_q <= match;
        end
    end

    // Event counter: written by software, reset by a still-present trigger
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            evcnt_q <= 16'h0000;
        end else if (do_wr && wsel == capu_pkg::CAPU_R_EVCNT) begin
            if (wstrb_q[0]) begin
                evcnt_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                evcnt_q[15:8] <= wdata_q[15:8];
            end
        end else if (tick) begin
            if (trig) begin
                evcnt_q <= 16'h0000;
            end else begin
                evcnt_q <= evcnt_q + 16'h0001;
            end
        end
    end

    // Compare output latch; cleared by a zero control write or mode off
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            cmp_lat_q <= 1'b0;
        end else if (wr_ctrl && wdata_q[5:0] == 6'h00) begin
            cmp_lat_q <= 1'b0;
        end else if (mode == capu_pkg::CAPU_MODE_OFF) begin
            cmp_lat_q <= 1'b0;
        end else if (match_rise && mode == capu_pkg::CAPU_MODE_SET) begin
            cmp_lat_q <= 1'b1;
        end else if (match_rise && mode == capu_pkg::CAPU_MODE_CLR) begin
            cmp_lat_q <= 1'b0;
        end
    end

    // Conversion start pulse on a new trigger when the converter is enabled
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            trig_q <= 1'b0;
            adc_q  <= 1'b0;
        end else begin
            trig_q <= trig;
            adc_q  <= trig && !trig_q && aux_q[`CAPU_AUX_ADC];
        end
    end
    assign ADC_START_O = adc_q;

    // ------------------------------------------------------------------------
    // Status flags: write one to clear, a same-cycle event wins
    // ------------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            stat_q <= 3'h0;
        end else begin
            if (do_wr && wsel == capu_pkg::CAPU_R_STAT && wstrb_q[0]) begin
                stat_q <= stat_q & ~wdata_q[2:0];
            end
            if (match_rise) begin
                stat_q[`CAPU_ST_MATCH] <= 1'b1;
            end
            if (tick && !trig && evcnt_q == 16'hffff) begin
                stat_q[`CAPU_ST_OVF] <= 1'b1;
            end
            if (pif.period_end) begin
                stat_q[`CAPU_ST_PEND] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // PWM time base
    // ------------------------------------------------------------------------
    assign pif.pwm_en       = is_pwm;
    assign pif.run          = ptctl_q[`CAPU_PT_ON_BIT] && awake;
    assign pif.prescale     = ptctl_q[1:0];
    assign pif.period_limit = plim_q;
    assign pif.duty_low     = dlo_q;
    assign pif.duty_lsb     = ctrl_q[`CAPU_CTL_DC_LSB +: 2];
    assign pif.duty_high    = dhi_q;
    assign pif.cnt_wr       = do_wr && wsel == capu_pkg::CAPU_R_PCNT && wstrb_q[0];
    assign pif.cnt_wdata    = wdata_q[7:0];

    capu_pwm u_pwm (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .pif     (pif)
    );

    // ------------------------------------------------------------------------
    // Pin: compare latch or PWM level, driven only in set/clear/PWM modes
    // ------------------------------------------------------------------------
    assign drive = is_pwm || mode == capu_pkg::CAPU_MODE_SET
                          || mode == capu_pkg::CAPU_MODE_CLR;
    assign PIN_OE_O = drive && !aux_q[`CAPU_AUX_DIR];
    assign PIN_O    = is_pwm ? (pif.level ^ ctrl_q[1]) : cmp_lat_q;
endmodule // capu_top
`default_nettype wire
